/* src/isr_pkg.sv */
package isr_pkg;
   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_DEVICE_STATUS = 8'h00;
   localparam logic [7:0] OFS_PRESS_OUTPUT_STATE = 8'h01;
   localparam logic [7:0] OFS_CHANNEL0_RESULT_LOW = 8'h02;
   localparam logic [7:0] OFS_CHANNEL0_RESULT_HIGH = 8'h03;
   localparam logic [7:0] RST_DEVICE_STATUS = 8'h40;
   localparam logic [7:0] RST_PRESS_OUTPUT_STATE = 8'h00;
   localparam logic [7:0] RST_CHANNEL0_RESULT = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int ST_PRESS_SUMMARY = 7;
   localparam int ST_READY = 6;
   localparam int ST_WRITE_ALLOWED = 5;
   localparam int ST_SATURATION = 4;
   localparam int ST_WATCHDOG = 3;
   localparam int ST_OSC_START = 2;
   localparam int ST_PRESS_TIMEOUT = 1;
   localparam int ST_REG_INTEGRITY = 0;
   localparam int OS_NEW_DATA = 4;
   localparam int NUM_CH = 4;
   localparam int RESULT_W = 12;
   localparam logic [11:0] RESULT_MAX = 12'h7ff;
   localparam logic [11:0] RESULT_MIN = 12'h800;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam longint CLK_HZ = 250_000_000;
   localparam longint PRESS_TIMEOUT_S = 50;
   localparam longint PRESS_TIMEOUT_CYC = PRESS_TIMEOUT_S * CLK_HZ;
   localparam int TMR_W = 34;

   // read port request
   typedef struct packed {
      logic rd;
      logic [7:0] addr;
   } isr_rd_req_t;

   // events from the measurement core, one-cycle pulses except press
   typedef struct packed {
      logic [3:0] press;
      logic [3:0] result_valid;
      logic new_data;
      logic capture_busy;
      logic watchdog_err;
      logic osc_start_err;
      logic reg_integrity_err;
   } isr_evt_t;
endpackage

/* src/isr_press_timer.sv */
`timescale 1ns/100ps
// counts how long one channel's press output has been held
module isr_press_timer #(
   parameter longint LIMIT = 64'd12500000000
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic press_i,
   input wire logic disable_i,
   output logic expired_o
);
   import isr_pkg::*;
   logic [TMR_W-1:0] cnt_reg, cnt_next;
   logic done_reg, done_next;

   // -----------------------------------------------------------------
   // counter
   // -----------------------------------------------------------------
   // saturates so a stuck button fires once per press, not repeatedly
   always_comb begin
      cnt_next = cnt_reg;
      done_next = 1'b0;
      if (!press_i) begin
         cnt_next = '0;
      end else if (cnt_reg < TMR_W'(LIMIT)) begin
         cnt_next = cnt_reg + TMR_W'(1);
         done_next = (cnt_next == TMR_W'(LIMIT)) && !disable_i; // RQ8 RQ9
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign expired_o = done_reg;
endmodule // isr_press_timer

/* src/isr_status_regs.sv */
`timescale 1ns/100ps
// What this block does
// RQ1: status bit 7 is OR of presses
// RQ2: status read clears sticky status flags
// RQ3: ready bit low until ready, resets high
// RQ4: bit 5 shows registers accept writes
// RQ5: bit 4 sets on result saturation
// RQ6: bit 3 sets on watchdog, halts conversions
// RQ7: bit 2 sets on oscillator start failure
// RQ8: bit 1 sets on press beyond timeout
// RQ9: press limit disable suppresses timeout flag
// RQ10: bit 0 sets on register integrity error
// RQ11: new-data bit, cleared by read
// RQ12: output bits 3..0 show channel presses
// RQ13: low result register holds bits 7..0
// RQ14: high register holds bits 11..8
// RQ15: after full reset wait for ready
// RQ16: events in read cycle stay set
module isr_status_regs #(
   parameter longint PRESS_TIMEOUT = isr_pkg::PRESS_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire isr_pkg::isr_rd_req_t req_i,
   output logic [7:0] rdata_o,
   input wire isr_pkg::isr_evt_t evt_i,
   input wire logic [isr_pkg::NUM_CH*isr_pkg::RESULT_W-1:0] result_i,
   input wire logic press_limit_disable_i,
   input wire logic chip_ready_i,
   input wire logic write_allowed_flag_i,
   output logic conversions_halt_o
);
   import isr_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic [7:0] status_reg, status_next;
   logic new_data_reg, new_data_next;
   logic [RESULT_W-1:0] channel0_result_reg, channel0_result_next;
   logic halt_reg, halt_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [NUM_CH-1:0] timeout_hit;
   logic sat_hit;
   logic rd_status, rd_outstate;

   // a result at either rail counts as saturated
   function automatic logic is_extreme(input logic [RESULT_W-1:0] v);
      return (v == RESULT_MAX) || (v == RESULT_MIN);
   endfunction

   // -----------------------------------------------------------------
   // press timers
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_tmr
         isr_press_timer #(
            .LIMIT(PRESS_TIMEOUT)
         ) u_tmr (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .press_i(evt_i.press[g]),
            .disable_i(press_limit_disable_i),
            .expired_o(timeout_hit[g])
         );
      end
   endgenerate

   // saturation check over every channel with a fresh result
   always_comb begin
      sat_hit = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (evt_i.result_valid[i] && is_extreme(result_i[i*RESULT_W +: RESULT_W])) begin
            sat_hit = 1'b1; // RQ5
         end
      end
   end

   assign rd_status = req_i.rd && (req_i.addr == OFS_DEVICE_STATUS);
   assign rd_outstate = req_i.rd && (req_i.addr == OFS_PRESS_OUTPUT_STATE);

   // -----------------------------------------------------------------
   // flag update
   // -----------------------------------------------------------------
   // clear applies first, then the set, so a same-cycle event survives
   always_comb begin
      status_next = status_reg;
      new_data_next = new_data_reg;
      halt_next = halt_reg;
      channel0_result_next = channel0_result_reg;
      if (rd_status) begin
         status_next[ST_PRESS_SUMMARY] = 1'b0; // RQ2
         status_next[ST_SATURATION] = 1'b0; // RQ2
         status_next[ST_WATCHDOG] = 1'b0; // RQ2
         status_next[ST_OSC_START] = 1'b0; // RQ2
         status_next[ST_PRESS_TIMEOUT] = 1'b0; // RQ2
         status_next[ST_REG_INTEGRITY] = 1'b0; // RQ2
      end
      if (|evt_i.press) status_next[ST_PRESS_SUMMARY] = 1'b1; // RQ1 RQ16
      if (sat_hit) status_next[ST_SATURATION] = 1'b1; // RQ5 RQ16
      if (evt_i.watchdog_err) begin
         status_next[ST_WATCHDOG] = 1'b1; // RQ6 RQ16
         halt_next = 1'b1; // RQ6
      end
      if (evt_i.osc_start_err) status_next[ST_OSC_START] = 1'b1; // RQ7 RQ16
      if (|timeout_hit) status_next[ST_PRESS_TIMEOUT] = 1'b1; // RQ8 RQ16
      if (evt_i.reg_integrity_err) status_next[ST_REG_INTEGRITY] = 1'b1; // RQ10 RQ16
      status_next[ST_READY] = chip_ready_i; // RQ3 RQ15
      status_next[ST_WRITE_ALLOWED] = write_allowed_flag_i; // RQ4
      if (rd_outstate || evt_i.capture_busy) new_data_next = 1'b0; // RQ11
      if (evt_i.new_data) new_data_next = 1'b1; // RQ11 RQ16
      if (evt_i.result_valid[0]) channel0_result_next = result_i[RESULT_W-1:0]; // RQ13
   end

   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------
   // value returned is the pre-clear one, captured in the read cycle
   always_comb begin
      rdata_next = UNMAPPED_READ;
      if (req_i.rd) begin
         case (req_i.addr)
            OFS_DEVICE_STATUS: rdata_next = status_reg; // RQ16
            OFS_PRESS_OUTPUT_STATE: begin
               rdata_next = RST_PRESS_OUTPUT_STATE;
               rdata_next[OS_NEW_DATA] = new_data_reg; // RQ11
               rdata_next[NUM_CH-1:0] = evt_i.press; // RQ12
            end
            OFS_CHANNEL0_RESULT_LOW: rdata_next = channel0_result_reg[DATA_W-1:0]; // RQ13
            OFS_CHANNEL0_RESULT_HIGH: begin
               // upper nibble reads zero, the result is only twelve bits wide
               rdata_next = {4'h0, channel0_result_reg[RESULT_W-1:DATA_W]}; // RQ14
            end
            default: rdata_next = UNMAPPED_READ;
         endcase
      end else begin
         rdata_next = rdata_reg;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_reg <= RST_DEVICE_STATUS; // RQ3
         new_data_reg <= 1'b0;
         halt_reg <= 1'b0;
         channel0_result_reg <= RESULT_W'(RST_CHANNEL0_RESULT);
         rdata_reg <= 8'h00;
      end else begin
         status_reg <= status_next;
         new_data_reg <= new_data_next;
         halt_reg <= halt_next;
         channel0_result_reg <= channel0_result_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign conversions_halt_o = halt_reg; // RQ6
endmodule // isr_status_regs

/* dv/isr_status_regs_sva.sv */
`timescale 1ns/100ps
module isr_status_regs_sva (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire isr_pkg::isr_rd_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire isr_pkg::isr_evt_t evt_i,
   input wire logic [47:0] result_i,
   input wire logic press_limit_disable_i,
   input wire logic chip_ready_i,
   input wire logic write_allowed_flag_i,
   input wire logic conversions_halt_o
);
   import isr_pkg::*;
   // -----------------------------------------
   // read data and halt checks
   // -----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // strobe per mapped offset, bit n for offset n
   logic [3:0] h;
   assign h = {4{req_i.rd}} & {req_i.addr == 8'h03, req_i.addr == 8'h02,
                               req_i.addr == 8'h01, req_i.addr == 8'h00};
   property p_sum; h[0] && $past(|evt_i.press) |=> rdata_o[7]; endproperty
   a_sum: assert property (p_sum) else $error("summary lost");
   property p_rdy; h[0] |=> rdata_o[6] == $past(chip_ready_i, 2); endproperty
   a_rdy: assert property (p_rdy) else $error("ready bit wrong");
   property p_wa; h[0] |=> rdata_o[5] == $past(write_allowed_flag_i, 2); endproperty
   a_wa: assert property (p_wa) else $error("write bit wrong");
   // a quiet first read leaves nothing for the second to see
   property p_clr; (h[0] && !(|evt_i)) ##1 h[0] |=> {rdata_o[7], rdata_o[4:0]} == 6'h00; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_os; h[1] |=> rdata_o[3:0] == $past(evt_i.press); endproperty
   a_os: assert property (p_os) else $error("press bits wrong");
   property p_hi; h[3] |=> rdata_o[7:4] == 4'h0; endproperty
   a_hi: assert property (p_hi) else $error("high byte upper bits");
   property p_halt; evt_i.watchdog_err || conversions_halt_o |=> conversions_halt_o; endproperty
   a_halt: assert property (p_halt) else $error("halt missing");
   property p_nd; h[1] && $past(evt_i.new_data, 2) && !$past(evt_i.capture_busy)
      && !$past(h[1]) |=> rdata_o[4]; endproperty
   a_nd: assert property (p_nd) else $error("new data lost");
endmodule // isr_status_regs_sva
bind isr_status_regs isr_status_regs_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .req_i(req_i), .rdata_o(rdata_o), .evt_i(evt_i), .result_i(result_i),
   .press_limit_disable_i(press_limit_disable_i), .chip_ready_i(chip_ready_i),
   .write_allowed_flag_i(write_allowed_flag_i), .conversions_halt_o(conversions_halt_o));

/* dv/isr_host_model.sv */
`timescale 1ns/100ps
// host side of the read port, drives on falling edges only
module isr_host_model (
   input wire logic clk_i,
   output isr_pkg::isr_rd_req_t req_o
);
   import isr_pkg::*;
   initial req_o = '{1'b0, 8'hff};
   // k keeps the strobe up so the next read follows back to back
   task automatic rd(input logic [7:0] a, input bit k);
      @(negedge clk_i);
      req_o = '{1'b1, a};
      if (!k) begin
         @(negedge clk_i);
         req_o = '{1'b0, ~a}; // idle address inverted, never a stale copy
      end
   endtask
endmodule // isr_host_model

/* dv/isr_status_regs_tb.sv */
`timescale 1ns/100ps
module isr_status_regs_tb;
   import isr_pkg::*;
   logic clk_i = 0, rst_b_i = 0, dis = 0, rdy = 1, wa = 0, rd_d = 0, halt;
   logic [12:0] ev = '0;
   logic [47:0] res = '0;
   logic [11:0] v;
   logic [7:0] rdata, q[$];
   isr_rd_req_t req;
   int fail_count = 0, n_tests = 0, cyc = 0, seed = 61847, i;
   initial forever #2 clk_i = ~clk_i;
   isr_host_model u_host (.clk_i(clk_i), .req_o(req));
   isr_status_regs #(.PRESS_TIMEOUT(20)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .req_i(req), .rdata_o(rdata), .evt_i(isr_evt_t'(ev)), .result_i(res),
      .press_limit_disable_i(dis), .chip_ready_i(rdy), .write_allowed_flag_i(wa),
      .conversions_halt_o(halt));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // note the expectation first, so the monitor always finds it
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit k = 0);
      q.push_back(e);
      u_host.rd(a, k);
   endtask
   task automatic pulse(input int b);
      @(negedge clk_i);
      ev[b] = 1'b1;
      @(negedge clk_i);
      ev[b] = 1'b0;
   endtask
   // -----------------------------------------
   // monitor and hang guard
   // -----------------------------------------
   always @(posedge clk_i) rd_d <= req.rd;
   always @(negedge clk_i) begin
      if (rd_d === 1'b1) chk(rdata, q.pop_front());
      if (++cyc == 3000) begin
         fail_count++;
         test_done();
      end
   end
   initial begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      rst_b_i = 1'b1;
      rd(8'h00, 8'h40);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h55, 8'h00);
      // integrity, oscillator, watchdog: set, then cleared by a back to back read
      for (i = 0; i < 3; i++) begin
         pulse(i);
         rd(8'h00, i == 2 ? 8'h48 : i == 1 ? 8'h44 : 8'h41, 1);
         rd(8'h00, 8'h40);
      end
      chk({7'h0, halt}, 8'h01);
      // both extremes, then random results; ch0 valid is ev bit 5
      for (i = 0; i < 4; i++) begin
         v = i == 0 ? 12'h7ff : i == 1 ? 12'h800 : 12'($random(seed));
         res = {$random(seed), 4'h5, v};
         pulse(5);
         rd(8'h02, v[7:0]);
         rd(8'h03, {4'h0, v[11:8]});
         rd(8'h00, (v == 12'h7ff || v == 12'h800) ? 8'h50 : 8'h40);
      end
      // a rail on channel 1 also saturates, and leaves channel 0 alone
      res[23:12] = 12'h800;
      pulse(6);
      rd(8'h00, 8'h50);
      rd(8'h02, v[7:0]);
      $display("test flags and results done");
      // short hold stays below the timeout
      ev[12:9] = 4'h5;
      rd(8'h01, 8'h05);
      ev[12:9] = 4'h0;
      rd(8'h00, 8'hc0);
      rd(8'h00, 8'h40);
      for (i = 0; i < 2; i++) begin
         dis = (i == 0);
         ev[9] = 1'b1;
         rd(8'h00, 8'hc0);
         repeat (28) @(negedge clk_i);
         ev[9] = 1'b0;
         repeat (3) @(negedge clk_i);
         rd(8'h00, i == 0 ? 8'hc0 : 8'hc2);
      end
      pulse(4);
      rd(8'h01, 8'h10, 1);
      rd(8'h01, 8'h00);
      pulse(4);
      pulse(3);
      rd(8'h01, 8'h00);
      // event in the read cycle itself must survive the clear
      fork
         rd(8'h00, 8'h40);
         pulse(1);
      join
      rd(8'h00, 8'h44);
      rdy = 1'b0;
      wa = 1'b1;
      rd(8'h00, 8'h20);
      rdy = 1'b1;
      @(negedge clk_i);
      rd(8'h00, 8'h60);
      repeat (2) @(negedge clk_i);
      $display("test press and ready done");
      test_done();
   end
endmodule // isr_status_regs_tb
